// file: sim/reset_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module reset_link_model (
  input wire logic clk,
  input wire logic holdStart,
  input wire logic [9:0] holdLen,
  input wire logic driveEnN,
  output logic resetInN
);
  logic [9:0] holdCnt = 10'h000;
  always_ff @(posedge clk) begin
    if (holdStart) begin
      holdCnt <= (holdLen < 10'h002) ? 10'h002 : holdLen;
    end else if (holdCnt != 10'h000) begin
      holdCnt <= holdCnt - 10'h001;
    end
  end
  // Wired-AND of the external switch and the open drain; the pull-up wins when both let go.
  assign resetInN = (holdCnt == 10'h000) && driveEnN;
endmodule
`default_nettype wire

// file: sim/reset_output_bidir_strap_latch_bench.sv
`timescale 1ns/1ps
`default_nettype none
module reset_output_bidir_strap_latch_bench;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic swResetReq = 1'h0;
  logic wdtResetReq = 1'h0;
  logic endOfInitInstr = 1'h0;
  logic pdCapAboveThreshold = 1'h1;
  logic externalAccessN = 1'h1;
  logic [15:0] strapPort = 16'h5A3C;
  logic holdStart = 1'h0;
  logic [9:0] holdLen = 10'h014;
  logic resetInN, errSeen;
  logic [31:0] prdata, rd;
  logic pready, pslverr, resetOutN, resetInDriveOut, resetInDriveEnN, pdCapDischarge;
  logic pdCapPullUp, internalReset, initPhase, writeConfigStrap, busActive0, aleLengthen0;
  logic bootloaderSel, adaptModeStrap, emulationStrap;
  logic [2:0] clockConfigStrap;
  logic [1:0] segmentAddrLinesSel, chipSelectCountSel, busTypeField;
  logic [15:0] expStrap = 16'hFFFF;
  int err_total = 0;
  int compares = 0;
  reset_output_bidir_strap_latch uut (
    .clk, .rst, .clkEn(1'h1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .swResetReq, .wdtResetReq, .endOfInitInstr, .resetInN, .pdCapAboveThreshold,
    .externalAccessN, .strapPort, .resetOutN, .resetInDriveOut, .resetInDriveEnN,
    .pdCapDischarge, .pdCapPullUp, .internalReset, .initPhase, .clockConfigStrap,
    .segmentAddrLinesSel, .chipSelectCountSel, .writeConfigStrap, .busTypeField,
    .busActive0, .aleLengthen0, .bootloaderSel, .adaptModeStrap, .emulationStrap
  );
  reset_link_model link (.clk, .holdStart, .holdLen, .driveEnN(resetInDriveEnN), .resetInN);
  always #5 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    rd = prdata;
    errSeen = pslverr;
    chk(pready, 1'h1, "apb ready");
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wait_exit;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (internalReset !== 1'h0 && n < 3000);
    chk(internalReset, 1'h0, "sequence exit");
  endtask
  task automatic chk_straps(input logic [15:0] mask);
    logic [15:0] got;
    got = {clockConfigStrap, segmentAddrLinesSel, chipSelectCountSel, writeConfigStrap,
      busTypeField, 1'h0, bootloaderSel, 2'h0, adaptModeStrap, emulationStrap};
    expStrap = (expStrap & ~mask) | (strapPort & mask);
    chk(got, expStrap & 16'hFFD3, "strap outputs");
    apb(1'h0, 12'h000, 32'h0000_0000);
    chk(rd, {24'h00_0000, expStrap[15:8]}, "strap register");
    apb(1'h0, 12'h008, 32'h0000_0000);
    chk(rd, {21'h00_0000, {2{externalAccessN}}, 1'h0, expStrap[7:6], 6'h00}, "bus config");
  endtask
  task automatic chk_kind(input logic [31:0] exp);
    apb(1'h0, 12'h00C, 32'h0000_0000);
    chk(rd & 32'h0000_001C, exp, "reset kind");
  endtask
  task automatic test_power_on;
    wait_exit;
    chk_straps(16'hFFFF);
    chk(resetOutN, 1'h0, "output in init");
    chk_kind(32'h0000_0000);
    apb(1'h0, 12'h010, 32'h0000_0000);
    chk(errSeen, 1'h1, "unmapped error");
    apb(1'h1, 12'h004, 32'h0000_0018);
    apb(1'h0, 12'h004, 32'h0000_0000);
    chk(rd & 32'h0000_0018, 32'h0000_0018, "config set");
    @(posedge clk);
    endOfInitInstr <= 1'h1;
    @(posedge clk);
    endOfInitInstr <= 1'h0;
    @(posedge clk);
    chk(resetOutN, 1'h1, "output after init");
    apb(1'h1, 12'h004, 32'h0000_0000);
    apb(1'h0, 12'h004, 32'h0000_0000);
    chk(rd & 32'h0000_0018, 32'h0000_0018, "config locked");
    $display("test power_on done");
  endtask
  task automatic test_soft;
    strapPort <= 16'hC3A5;
    @(posedge clk);
    swResetReq <= 1'h1;
    @(posedge clk);
    swResetReq <= 1'h0;
    repeat (3) @(posedge clk);
    chk(resetOutN, 1'h0, "output at start");
    chk(resetInDriveEnN, 1'h0, "pull-down on");
    wait_exit;
    chk_straps(16'h1FC0);
    chk(pdCapPullUp, 1'h1, "pull-up after sequence");
    apb(1'h0, 12'h004, 32'h0000_0000);
    chk(rd & 32'h0000_0008, 32'h0000_0000, "enable cleared");
    chk_kind(32'h0000_0010);
    apb(1'h1, 12'h004, 32'h0000_0018);
    apb(1'h0, 12'h004, 32'h0000_0000);
    chk(rd & 32'h0000_0018, 32'h0000_0018, "config rewritten");
    $display("test soft done");
  endtask
  // The outside line is held low past the pull-down release, so a new reset must follow.
  task automatic test_wdt_restart;
    strapPort <= 16'h3C5A;
    holdLen <= 10'h258;
    @(posedge clk);
    wdtResetReq <= 1'h1;
    holdStart <= 1'h1;
    @(posedge clk);
    wdtResetReq <= 1'h0;
    holdStart <= 1'h0;
    wait_exit;
    chk_straps(16'h1FFF);
    chk_kind(32'h0000_0008);
    $display("test wdt_restart done");
  endtask
  task automatic test_long;
    strapPort <= 16'h9669;
    pdCapAboveThreshold <= 1'h0;
    externalAccessN <= 1'h0;
    holdLen <= 10'h014;
    @(posedge clk);
    holdStart <= 1'h1;
    @(posedge clk);
    holdStart <= 1'h0;
    repeat (12) @(posedge clk);
    chk(pdCapDischarge, 1'h1, "discharge on");
    chk(internalReset, 1'h1, "async start");
    wait_exit;
    chk_straps(16'hFFFF);
    chk_kind(32'h0000_0004);
    pdCapAboveThreshold <= 1'h1;
    $display("test long done");
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    test_power_on;
    test_soft;
    test_wdt_restart;
    test_long;
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("Error at %0t: watchdog expired", $time);
    print_verdict;
  end
endmodule
`default_nettype wire

// file: sim/reset_seq_checker.sv
`timescale 1ns/1ps
`default_nettype none
module reset_seq_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic endOfInitInstr,
  input wire logic resetInN,
  input wire logic externalAccessN,
  input wire logic resetOutN,
  input wire logic resetInDriveOut,
  input wire logic resetInDriveEnN,
  input wire logic pdCapDischarge,
  input wire logic internalReset,
  input wire logic initPhase,
  input wire logic busActive0,
  input wire logic aleLengthen0
);
  logic [9:0] pdCnt;
  always_ff @(posedge clk) begin
    if (rst || resetInDriveEnN) begin
      pdCnt <= 10'h000;
    end else begin
      pdCnt <= pdCnt + 10'h001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  out_low_a: assert property (internalReset |-> !resetOutN)
    else $error("reset output high in sequence");
  out_rise_a: assert property ($rose(resetOutN) |-> $past(endOfInitInstr))
    else $error("reset output released early");
  end_of_init_instr_a: assert property (endOfInitInstr && !internalReset |=> resetOutN)
    else $error("reset output not released");
  pull_seq_a: assert property (!resetInDriveEnN |-> internalReset)
    else $error("pull-down outside sequence");
  drive_zero_a: assert property (resetInDriveOut == 1'h0)
    else $error("open drain data not low");
  pull_len_a: assert property ($rose(resetInDriveEnN) |-> pdCnt == 10'h200)
    else $error("pull-down length wrong");
  sample_wait_a: assert property ($rose(resetInDriveEnN) |-> internalReset [*4])
    else $error("left reset before sample");
  discharge_a: assert property ($stable(resetInN) [*8] |-> pdCapDischarge == !resetInN)
    else $error("discharge does not follow input");
  init_a: assert property (internalReset |-> initPhase)
    else $error("init phase low in sequence");
  bus_act_a: assert property ($fell(internalReset) |->
      busActive0 == externalAccessN && aleLengthen0 == externalAccessN)
    else $error("bus active bits wrong at exit");
  ready_a: assert property (pready == (psel && penable))
    else $error("pready wrong");
  unmapped_a: assert property (psel && !penable |=>
      pslverr == !($past(paddr) inside {12'h000, 12'h004, 12'h008, 12'h00C}))
    else $error("pslverr wrong");
  cover property ($rose(resetInDriveEnN));
  cover property ($fell(internalReset));
  cover property ($rose(resetOutN));
endmodule
bind reset_output_bidir_strap_latch reset_seq_checker chk (
  .clk, .rst, .psel, .penable, .paddr, .pready, .pslverr, .endOfInitInstr, .resetInN,
  .externalAccessN, .resetOutN, .resetInDriveOut, .resetInDriveEnN, .pdCapDischarge,
  .internalReset, .initPhase, .busActive0, .aleLengthen0
);
`default_nettype wire

// file: verilog/pin_sync3.sv
`timescale 1ns/1ps
`default_nettype none

// Three-stage pin synchroniser; a change is accepted once stages two and three agree.
module pin_sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] stable
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] stable_reg;
  logic [WIDTH-1:0] stable_next;

  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      stable_next[i] = (stage2_reg[i] == stage3_reg[i]) ? stage3_reg[i] : stable_reg[i];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stage1_reg <= RESET_VAL;
      stage2_reg <= RESET_VAL;
      stage3_reg <= RESET_VAL;
      stable_reg <= RESET_VAL;
    end else if (clkEn) begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      stable_reg <= stable_next;
    end
  end

  assign stable = stable_reg;

endmodule

`default_nettype wire

// file: verilog/reset_output_bidir_strap_latch.sv
// Operation
// - Reset output goes low at every sequence start.
// - Reset output held low until end-of-init.
// - Bidirectional reset enabled by config bit 3.
// - Enable writable only before end-of-init.
// - Pull reset input low during sequence.
// - Release pull-down, sample input 8 half-periods later.
// - Low sample starts a new hardware reset.
// - High sample exits per running reset kind.
// - Every reset sequence clears the enable bit.
// - Discharge capacitor pin while reset input low.
// - Pull-up capacitor pin after sequence if configured.
// - Capacitor pin low asynchronous, high synchronous; here both pass through the pin synchroniser.
// - Strap bits sampled depend on reset kind.
// - High strap byte shows in strap register.
// - Bus type straps, access-pin bits into bus config.
// - Latched straps drive internal logic outputs.
// - Sequence lasts 1024 half-periods, extended while low.
// - System config ignores writes after end-of-init.
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module reset_output_bidir_strap_latch (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic swResetReq,
  input wire logic wdtResetReq,
  input wire logic endOfInitInstr,
  input wire logic resetInN,
  input wire logic pdCapAboveThreshold,
  input wire logic externalAccessN,
  input wire logic [15:0] strapPort,
  output logic resetOutN,
  output logic resetInDriveOut,
  output logic resetInDriveEnN,
  output logic pdCapDischarge,
  output logic pdCapPullUp,
  output logic internalReset,
  output logic initPhase,
  output logic [2:0] clockConfigStrap,
  output logic [1:0] segmentAddrLinesSel,
  output logic [1:0] chipSelectCountSel,
  output logic writeConfigStrap,
  output logic [1:0] busTypeField,
  output logic busActive0,
  output logic aleLengthen0,
  output logic bootloaderSel,
  output logic adaptModeStrap,
  output logic emulationStrap
);

  localparam int PIN_W = reset_seq_pkg::STRAP_W + 3;

  function automatic logic addrIs(input logic [11:0] addr, input logic [11:0] offset);
    addrIs = (addr == offset);
  endfunction

  function automatic logic addrMapped(input logic [11:0] addr);
    addrMapped = addrIs(addr, reset_seq_pkg::ADDR_STRAP) ||
      addrIs(addr, reset_seq_pkg::ADDR_SYSTEM_CONFIG_REG) ||
      addrIs(addr, reset_seq_pkg::ADDR_BUS_CONFIG0) ||
      addrIs(addr, reset_seq_pkg::ADDR_STATUS);
  endfunction

  // Pin inputs: capacitor comparator, access pin, reset input, strap port.
  logic [PIN_W-1:0] pinStable;
  logic pdAbove;
  logic accessPinHigh;
  logic resetInHigh;
  logic [reset_seq_pkg::STRAP_W-1:0] strapStable;

  pin_sync3 #(
    .WIDTH(PIN_W),
    .RESET_VAL({3'b111, reset_seq_pkg::STRAP_RESET})
  ) pinSync (
    .clk(clk),
    .rst(rst),
    .clkEn(clkEn),
    .pinIn({pdCapAboveThreshold, externalAccessN, resetInN, strapPort}),
    .stable(pinStable)
  );

  assign strapStable = pinStable[reset_seq_pkg::STRAP_W-1:0];
  assign resetInHigh = pinStable[reset_seq_pkg::STRAP_W];
  assign accessPinHigh = pinStable[reset_seq_pkg::STRAP_W+1];
  assign pdAbove = pinStable[reset_seq_pkg::STRAP_W+2];

  // Sequencer state.
  reset_seq_pkg::seq_state_t state_reg, state_next;
  reset_seq_pkg::reset_kind_t kind_reg, kind_next;
  logic [reset_seq_pkg::CNT_W-1:0] seqCnt_reg, seqCnt_next;
  logic [reset_seq_pkg::CNT_W-1:0] lowCnt_reg, lowCnt_next;
  logic inInit_reg, inInit_next;
  logic bidirEnable_reg, bidirEnable_next;
  logic bidirActive_reg, bidirActive_next;
  logic powerdown_config_sel_reg, powerdown_config_sel_next;
  logic pullUp_reg, pullUp_next;
  logic resetOut_reg, resetOut_next;
  logic driveEnN_reg, driveEnN_next;
  logic discharge_reg, discharge_next;
  logic busAct_reg, busAct_next;
  logic ale_reg, ale_next;
  logic latchNow;
  logic [reset_seq_pkg::STRAP_W-1:0] latchMask;
  logic startSeq;
  logic sysconWrite;
  reset_seq_pkg::reset_kind_t startKind;

  assign sysconWrite = psel && penable && pwrite &&
    addrIs(paddr, reset_seq_pkg::ADDR_SYSTEM_CONFIG_REG);

  always_comb begin
    state_next = state_reg;
    kind_next = kind_reg;
    seqCnt_next = seqCnt_reg;
    inInit_next = inInit_reg;
    bidirEnable_next = bidirEnable_reg;
    bidirActive_next = bidirActive_reg;
    powerdown_config_sel_next = powerdown_config_sel_reg;
    pullUp_next = pullUp_reg;
    busAct_next = busAct_reg;
    ale_next = ale_reg;
    latchNow = 1'b0;
    startSeq = 1'b0;
    startKind = reset_seq_pkg::KIND_SHORT_HW;
    lowCnt_next = (resetInHigh || !driveEnN_reg) ? '0 :
      ((lowCnt_reg == reset_seq_pkg::CNT_MAX) ? lowCnt_reg : lowCnt_reg + 1'b1);

    // Software may touch the config register only while initialising.
    if (sysconWrite && state_reg == reset_seq_pkg::ST_INIT_RUN && inInit_reg) begin
      bidirEnable_next = pwdata[reset_seq_pkg::SYSTEM_CONFIG_REG_BIDIR_BIT];
      powerdown_config_sel_next = pwdata[reset_seq_pkg::SYSTEM_CONFIG_REG_POWERDOWN_CONFIG_SEL_BIT];
    end

    unique case (state_reg)
      reset_seq_pkg::ST_INIT_RUN: begin
        if (!resetInHigh && !pdAbove) begin
          // The three-flop input path delays this by a few cycles.
          startSeq = 1'b1;
          startKind = reset_seq_pkg::KIND_LONG_HW;
        end else if (!resetInHigh && lowCnt_reg >= reset_seq_pkg::SYNC_MIN) begin
          startSeq = 1'b1;
          startKind = reset_seq_pkg::KIND_SHORT_HW;
        end else if (wdtResetReq) begin
          startSeq = 1'b1;
          startKind = reset_seq_pkg::KIND_WATCHDOG;
        end else if (swResetReq) begin
          startSeq = 1'b1;
          startKind = reset_seq_pkg::KIND_SOFTWARE;
        end else if (endOfInitInstr && inInit_reg) begin
          inInit_next = 1'b0;
        end
      end
      reset_seq_pkg::ST_SEQ: begin
        seqCnt_next = seqCnt_reg + 1'b1;
        if (seqCnt_reg == reset_seq_pkg::SEQ_LAST) begin
          seqCnt_next = '0;
          state_next = bidirActive_reg ? reset_seq_pkg::ST_RELEASE : reset_seq_pkg::ST_EXTEND;
        end
      end
      reset_seq_pkg::ST_EXTEND: begin
        if (resetInHigh) begin
          latchNow = 1'b1;
        end
      end
      reset_seq_pkg::ST_RELEASE: begin
        seqCnt_next = seqCnt_reg + 1'b1;
        if (seqCnt_reg == reset_seq_pkg::SAMPLE_DONE) begin
          seqCnt_next = '0;
          if (!resetInHigh) begin
            startSeq = 1'b1;
            startKind = pdAbove ? reset_seq_pkg::KIND_SHORT_HW : reset_seq_pkg::KIND_LONG_HW;
          end else begin
            latchNow = 1'b1;
          end
        end
      end
    endcase

    // A short hardware reset becomes long when the pin stays low too long
    // or the capacitor drops; the own pull-down is excluded from that count.
    if (state_reg != reset_seq_pkg::ST_INIT_RUN && kind_reg == reset_seq_pkg::KIND_SHORT_HW &&
        driveEnN_reg && !resetInHigh && (lowCnt_reg > reset_seq_pkg::LONG_LIMIT || !pdAbove)) begin
      kind_next = reset_seq_pkg::KIND_LONG_HW;
    end

    if (startSeq) begin
      state_next = reset_seq_pkg::ST_SEQ;
      kind_next = startKind;
      seqCnt_next = '0;
      inInit_next = 1'b1;
      bidirActive_next = bidirEnable_reg;
      bidirEnable_next = 1'b0;
      pullUp_next = 1'b0;
    end

    if (latchNow) begin
      state_next = reset_seq_pkg::ST_INIT_RUN;
      bidirActive_next = 1'b0;
      pullUp_next = powerdown_config_sel_reg;
      busAct_next = accessPinHigh;
      ale_next = accessPinHigh;
    end

    resetOut_next = (state_next == reset_seq_pkg::ST_INIT_RUN) && !inInit_next;
    driveEnN_next = !((state_next == reset_seq_pkg::ST_SEQ) && bidirActive_next);
    discharge_next = !resetInHigh;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= reset_seq_pkg::ST_SEQ;
      kind_reg <= reset_seq_pkg::KIND_POWER_ON;
      seqCnt_reg <= '0;
      lowCnt_reg <= '0;
      inInit_reg <= 1'b1;
      bidirEnable_reg <= 1'b0;
      bidirActive_reg <= 1'b0;
      powerdown_config_sel_reg <= 1'b0;
      pullUp_reg <= 1'b0;
      resetOut_reg <= 1'b0;
      driveEnN_reg <= 1'b1;
      discharge_reg <= 1'b0;
      busAct_reg <= 1'b0;
      ale_reg <= 1'b0;
    end else if (clkEn) begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      seqCnt_reg <= seqCnt_next;
      lowCnt_reg <= lowCnt_next;
      inInit_reg <= inInit_next;
      bidirEnable_reg <= bidirEnable_next;
      bidirActive_reg <= bidirActive_next;
      powerdown_config_sel_reg <= powerdown_config_sel_next;
      pullUp_reg <= pullUp_next;
      resetOut_reg <= resetOut_next;
      driveEnN_reg <= driveEnN_next;
      discharge_reg <= discharge_next;
      busAct_reg <= busAct_next;
      ale_reg <= ale_next;
    end
  end

  // Strap latch: each bit reloads only when the running kind samples it.
  logic [reset_seq_pkg::STRAP_W-1:0] strap_reg;
  logic [reset_seq_pkg::STRAP_W-1:0] strap_next;

  always_comb begin
    unique case (kind_reg)
      reset_seq_pkg::KIND_SOFTWARE,
      reset_seq_pkg::KIND_WATCHDOG: latchMask = reset_seq_pkg::MASK_SOFT;
      reset_seq_pkg::KIND_SHORT_HW: latchMask = reset_seq_pkg::MASK_SHORT;
      default: latchMask = reset_seq_pkg::MASK_LONG;
    endcase
  end

  generate
    for (genvar i = 0; i < reset_seq_pkg::STRAP_W; i++) begin : strapBit
      assign strap_next[i] = (latchNow && latchMask[i]) ? strapStable[i] : strap_reg[i];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      strap_reg <= reset_seq_pkg::STRAP_RESET;
    end else if (clkEn) begin
      strap_reg <= strap_next;
    end
  end

  // Straps to the clock generator, port logic and internal logic.
  assign clockConfigStrap = strap_reg[reset_seq_pkg::STRAP_CLK_LSB +: 3];
  assign segmentAddrLinesSel = strap_reg[reset_seq_pkg::STRAP_SAL_LSB +: 2];
  assign chipSelectCountSel = strap_reg[reset_seq_pkg::STRAP_CHIP_SELECT_COUNT_SEL_LSB +: 2];
  assign writeConfigStrap = strap_reg[reset_seq_pkg::STRAP_WRC_BIT];
  assign busTypeField = strap_reg[reset_seq_pkg::STRAP_BUSTYPE_LSB +: 2];
  assign bootloaderSel = strap_reg[reset_seq_pkg::STRAP_BOOT_BIT];
  assign adaptModeStrap = strap_reg[reset_seq_pkg::STRAP_ADAPT_BIT];
  assign emulationStrap = strap_reg[reset_seq_pkg::STRAP_EMU_BIT];
  assign busActive0 = busAct_reg;
  assign aleLengthen0 = ale_reg;

  assign resetOutN = resetOut_reg;
  assign resetInDriveOut = 1'b0;
  assign resetInDriveEnN = driveEnN_reg;
  assign pdCapDischarge = discharge_reg;
  assign pdCapPullUp = pullUp_reg;
  assign internalReset = (state_reg != reset_seq_pkg::ST_INIT_RUN);
  assign initPhase = inInit_reg;

  // APB slave: read data is captured in the setup cycle, so the access
  // phase always completes without wait states.
  logic [31:0] prdata_reg, prdata_next;
  logic pslverr_reg, pslverr_next;

  always_comb begin
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    if (psel && !penable) begin
      prdata_next = 32'h0000_0000;
      pslverr_next = !addrMapped(paddr);
      if (!pwrite) begin
        if (addrIs(paddr, reset_seq_pkg::ADDR_STRAP)) begin
          prdata_next[7:0] = strap_reg[15:8];
        end else if (addrIs(paddr, reset_seq_pkg::ADDR_SYSTEM_CONFIG_REG)) begin
          prdata_next[reset_seq_pkg::SYSTEM_CONFIG_REG_BIDIR_BIT] = bidirEnable_reg;
          prdata_next[reset_seq_pkg::SYSTEM_CONFIG_REG_POWERDOWN_CONFIG_SEL_BIT] = powerdown_config_sel_reg;
        end else if (addrIs(paddr, reset_seq_pkg::ADDR_BUS_CONFIG0)) begin
          prdata_next[reset_seq_pkg::BUS_CONFIG0_TYPE_LSB +: 2] = busTypeField;
          prdata_next[reset_seq_pkg::BUS_CONFIG0_ALE_BIT] = ale_reg;
          prdata_next[reset_seq_pkg::BUS_CONFIG0_ACT_BIT] = busAct_reg;
        end else if (addrIs(paddr, reset_seq_pkg::ADDR_STATUS)) begin
          prdata_next[reset_seq_pkg::STATUS_INIT_BIT] = inInit_reg;
          prdata_next[reset_seq_pkg::STATUS_RESET_BIT] = internalReset;
          prdata_next[reset_seq_pkg::STATUS_KIND_LSB +: 3] = kind_reg;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (clkEn) begin
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;
  assign pready = psel && penable;

endmodule

`default_nettype wire

// file: verilog/reset_seq_pkg.sv
package reset_seq_pkg;

  // Clock and the half-period unit that reset timing is counted in.
  localparam int CLK_PERIOD_NS = 10;
  localparam int HALF_PERIOD_NS = CLK_PERIOD_NS / 2;
  localparam int CNT_W = 10;

  // Internal reset sequence: a least time, rounded up to whole cycles.
  localparam int SEQ_HALF_PERIODS = 1024;
  localparam int SEQ_CYCLES =
    (SEQ_HALF_PERIODS * HALF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] SEQ_LAST = CNT_W'(SEQ_CYCLES - 1);

  // Delay from pull-down release to sampling the reset input.
  localparam int SAMPLE_HALF_PERIODS = 8;
  localparam int SAMPLE_CYCLES =
    (SAMPLE_HALF_PERIODS * HALF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] SAMPLE_LAST = CNT_W'(SAMPLE_CYCLES - 1);
  // The three-flop input path shows a pin level four edges late, so the decision waits
  // until the level taken 8 half-periods after release has reached the stable flop.
  localparam int SYNC_DELAY_CYCLES = 4;
  localparam logic [CNT_W-1:0] SAMPLE_DONE = CNT_W'(SAMPLE_CYCLES - 1 + SYNC_DELAY_CYCLES);

  // Least low time on the reset input that starts a synchronous reset.
  localparam int SYNC_MIN_HALF_PERIODS = 4;
  localparam int SYNC_MIN_CYCLES =
    (SYNC_MIN_HALF_PERIODS * HALF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] SYNC_MIN = CNT_W'(SYNC_MIN_CYCLES);

  // Low time above which a hardware reset counts as long.
  localparam int LONG_HALF_PERIODS = 1032;
  localparam int LONG_CYCLES = (LONG_HALF_PERIODS * HALF_PERIOD_NS) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] LONG_LIMIT = CNT_W'(LONG_CYCLES);
  localparam logic [CNT_W-1:0] CNT_MAX = '1;

  // Register byte offsets.
  localparam logic [11:0] ADDR_STRAP = 12'h000;
  localparam logic [11:0] ADDR_SYSTEM_CONFIG_REG = 12'h004;
  localparam logic [11:0] ADDR_BUS_CONFIG0 = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;

  // Field positions.
  localparam int SYSTEM_CONFIG_REG_BIDIR_BIT = 3;
  localparam int SYSTEM_CONFIG_REG_POWERDOWN_CONFIG_SEL_BIT = 4;
  localparam int BUS_CONFIG0_TYPE_LSB = 6;
  localparam int BUS_CONFIG0_ALE_BIT = 9;
  localparam int BUS_CONFIG0_ACT_BIT = 10;
  localparam int STATUS_INIT_BIT = 0;
  localparam int STATUS_RESET_BIT = 1;
  localparam int STATUS_KIND_LSB = 2;

  // Strap port bit positions.
  localparam int STRAP_EMU_BIT = 0;
  localparam int STRAP_ADAPT_BIT = 1;
  localparam int STRAP_BOOT_BIT = 4;
  localparam int STRAP_BUSTYPE_LSB = 6;
  localparam int STRAP_WRC_BIT = 8;
  localparam int STRAP_CHIP_SELECT_COUNT_SEL_LSB = 9;
  localparam int STRAP_SAL_LSB = 11;
  localparam int STRAP_CLK_LSB = 13;
  localparam int STRAP_W = 16;

  // Which strap bits each reset kind samples.
  localparam logic [STRAP_W-1:0] MASK_SOFT = 16'h1FC0;
  localparam logic [STRAP_W-1:0] MASK_SHORT = 16'h1FFF;
  localparam logic [STRAP_W-1:0] MASK_LONG = 16'hFFFF;
  localparam logic [STRAP_W-1:0] STRAP_RESET = 16'hFFFF;

  typedef enum logic [2:0] {
    KIND_POWER_ON,
    KIND_LONG_HW,
    KIND_SHORT_HW,
    KIND_WATCHDOG,
    KIND_SOFTWARE
  } reset_kind_t;

  typedef enum logic [1:0] {
    ST_SEQ,
    ST_EXTEND,
    ST_RELEASE,
    ST_INIT_RUN
  } seq_state_t;

endpackage
